// ==== src/lfc_top.sv ====
// load-adaptive fullstep control with apb registers and driver handshake
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
//
// Notes on behaviour
// RL1: software sets chopper switch velocity slightly below fullstep threshold.
// RL2: low-velocity cover register holds microstep chopper settings.
// RL3: high-velocity cover register holds constant off-time chopper settings.
// RL4: automatic cover bit set makes device send cover datagrams itself.
// RL5: auto on, below threshold: low-velocity settings go to driver.
// RL6: auto on, fullstep region: high-velocity settings go to driver.
// RL7: feedback pin takes driver feedback; enable pin drives driver enable.
// RL8: driver setup for handshake goes only through cover datagrams.
// RL9: handshake selected by format 1101 or 1100 and mode 01.
// RL10: handshake: enable pin high while velocity at or above threshold.
// RL11: driver waits for next fullstep position before switching.
// RL12: driver produces the feedback signal seen on the feedback pin.
// RL13: handshake: device keeps making microsteps, driver does fullstep.
// RL14: count cycles of asserted feedback; force step at timer value.
// RL15: software should enable automatic cover transfer.
// RL16: fullstep threshold register is 24 bits and write-only.
// RL17: low-speed timer register is 32 bits and write-only.
// RL18: fullstep active when enabled and absolute velocity above threshold.
// RL19: each cover datagram sent once per switch-threshold crossing.
//
module lfc_top (
  input  wire logic                      I_CORE_CLK,
  input  wire logic                      I_RSTN,
  input  wire logic                      I_PSEL,
  input  wire logic                      I_PENABLE,
  input  wire logic                      I_PWRITE,
  input  wire logic [lfc_pkg::ADDR_W-1:0] I_PADDR,
  input  wire logic [31:0]               I_PWDATA,
  output logic      [31:0]               O_PRDATA,
  output logic                           O_PREADY,
  output logic                           O_PSLVERR,
  input  wire logic [31:0]               I_ACTUAL_VELOCITY,
  input  wire logic                      I_FEEDBACK_INPUT_PIN,
  output logic                           O_FULLSTEP_ENABLE_OUTPUT_PIN,
  output logic                           O_FULLSTEP_ACTIVE,
  output logic                           O_STEP_PAUSE,
  output logic                           O_FORCE_STEP,
  output logic                           O_COVER_VALID,
  output logic      [31:0]               O_COVER_DATA,
  input  wire logic                      I_COVER_READY
);

  typedef struct packed {
    logic [31:0]                       gen;
    logic [31:0]                       refc;
    logic [31:0]                       drv;
    logic [31:0]                       sw_vel;
    logic [lfc_pkg::FS_VEL_W-1:0]      fs_vel;
    logic [lfc_pkg::LS_TIMER_W-1:0]    ls_tim;
    logic [31:0]                       cov_lo;
    logic [31:0]                       cov_hi;
    logic                              pready;
    logic                              pslverr;
    logic [31:0]                       prdata;
    logic                              fs_active;
    logic                              en_pin;
    logic                              step_pause;
    logic                              force_step;
    logic [lfc_pkg::LS_TIMER_W-1:0]    ls_cnt;
    logic                              side;
    lfc_pkg::lfc_cover_state_t         cov_st;
    logic                              cover_valid;
    logic [31:0]                       cover_data;
  } lfc_state_t;

  lfc_state_t  q;
  lfc_state_t  d;
  logic        feedback;
  logic [31:0] abs_vel;
  logic [31:0] fs_vel_ext;
  logic [9:0]  idx;
  logic        mode_on;
  logic        hs_variant;
  logic        auto_cover;
  logic        above_switch;
  logic        acc;

  ////////////////////////////////////////////////////////////////////////////
  // feedback pin synchroniser
  lfc_sync3 u_fb_sync (
    .i_clk   (I_CORE_CLK),
    .i_rstn  (I_RSTN),
    .i_pin   (I_FEEDBACK_INPUT_PIN), // [RL7]
    .o_level (feedback)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoded configuration and velocity magnitude
  assign abs_vel      = I_ACTUAL_VELOCITY[31] ? (32'h0 - I_ACTUAL_VELOCITY)
                                              : I_ACTUAL_VELOCITY;
  assign fs_vel_ext   = {8'h00, q.fs_vel};
  assign idx          = I_PADDR[lfc_pkg::IDX_MSB:lfc_pkg::IDX_LSB];
  assign acc          = I_PSEL && I_PENABLE;
  assign mode_on      = q.gen[lfc_pkg::MODE_MSB:lfc_pkg::MODE_LSB]
                        == lfc_pkg::MODE_ON;
  assign hs_variant   = mode_on &&                                // [RL9]
                        (q.drv[lfc_pkg::FMT_MSB:lfc_pkg::FMT_LSB]
                           == lfc_pkg::FMT_HS_A ||
                         q.drv[lfc_pkg::FMT_MSB:lfc_pkg::FMT_LSB]
                           == lfc_pkg::FMT_HS_B);
  assign auto_cover   = q.refc[lfc_pkg::AUTO_COVER];
  assign above_switch = abs_vel > q.sw_vel;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for bus slave, fullstep logic and cover sender
  always_comb begin
    d = q;
    // one wait state: answer on the second access cycle
    d.pready = acc && !q.pready;
    if (acc && !q.pready) begin
      d.pslverr = 1'b0;
      d.prdata  = lfc_pkg::REG_RESET;
      unique case (idx)
        lfc_pkg::IDX_GENERAL:   d.prdata = q.gen;
        lfc_pkg::IDX_REFERENCE: d.prdata = q.refc;
        lfc_pkg::IDX_DRV_OUT:   d.prdata = q.drv;
        lfc_pkg::IDX_STATUS: begin
          d.prdata[lfc_pkg::ST_FS_ACT]   = q.fs_active;
          d.prdata[lfc_pkg::ST_EN_PIN]   = q.en_pin;
          d.prdata[lfc_pkg::ST_FEEDBACK] = feedback;
          d.prdata[lfc_pkg::ST_SIDE]     = q.side;
          d.prdata[lfc_pkg::ST_BUSY]     = q.cover_valid;
          d.prdata[lfc_pkg::ST_HS]       = hs_variant;
        end
        lfc_pkg::IDX_SW_VEL:    d.prdata = q.sw_vel;
        // write-only registers read as zero
        lfc_pkg::IDX_FS_VEL:    d.prdata = lfc_pkg::REG_RESET; // [RL16]
        lfc_pkg::IDX_LS_TIMER:  d.prdata = lfc_pkg::REG_RESET; // [RL17]
        lfc_pkg::IDX_COVER_LO:  d.prdata = q.cov_lo;
        lfc_pkg::IDX_COVER_HI:  d.prdata = q.cov_hi;
        default:                d.pslverr = 1'b1;
      endcase
    end else if (!acc) begin
      d.pslverr = 1'b0;
      d.prdata  = lfc_pkg::REG_RESET;
    end
    // writes land at the edge that samples pready high
    if (acc && q.pready && I_PWRITE) begin
      unique case (idx)
        lfc_pkg::IDX_GENERAL:   d.gen    = I_PWDATA;
        lfc_pkg::IDX_REFERENCE: d.refc   = I_PWDATA;
        lfc_pkg::IDX_DRV_OUT:   d.drv    = I_PWDATA;
        lfc_pkg::IDX_SW_VEL:    d.sw_vel = I_PWDATA;
        lfc_pkg::IDX_FS_VEL:
          d.fs_vel = I_PWDATA[lfc_pkg::FS_VEL_W-1:0];          // [RL16]
        lfc_pkg::IDX_LS_TIMER:  d.ls_tim = I_PWDATA;         // [RL17]
        lfc_pkg::IDX_COVER_LO:  d.cov_lo = I_PWDATA;         // [RL2]
        lfc_pkg::IDX_COVER_HI:  d.cov_hi = I_PWDATA;         // [RL3]
        default: ;
      endcase
    end

    // fullstep region and handshake enable
    d.fs_active = mode_on && (abs_vel > fs_vel_ext);        // [RL18]
    d.en_pin    = hs_variant && (abs_vel >= fs_vel_ext);    // [RL10]
    // handshake leaves fullstep to the driver, so steps never pause
    d.step_pause = mode_on && !hs_variant && feedback;      // [RL13]

    // low-speed timer: zero value disables forcing
    d.force_step = 1'b0;
    if (mode_on && feedback && (q.ls_tim != '0)) begin
      if (q.ls_cnt >= q.ls_tim - 32'h1) begin
        d.force_step = 1'b1;                                 // [RL14]
        d.ls_cnt     = '0;
      end else begin
        d.ls_cnt = q.ls_cnt + 32'h1;
      end
    end else begin
      d.ls_cnt = '0;
    end

    // cover sender: one datagram per crossing, held until taken
    unique case (q.cov_st)
      lfc_pkg::LFC_COVER_IDLE: begin
        if (auto_cover && (above_switch != q.side)) begin   // [RL4] [RL19]
          d.cover_valid = 1'b1;
          d.cover_data  = above_switch ? q.cov_hi           // [RL6]
                                       : q.cov_lo;          // [RL5]
          d.side        = above_switch;
          d.cov_st      = lfc_pkg::LFC_COVER_SEND;
        end
      end
      lfc_pkg::LFC_COVER_SEND: begin
        if (I_COVER_READY) begin
          d.cover_valid = 1'b0;
          d.cov_st      = lfc_pkg::LFC_COVER_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      q        <= '0;
      q.cov_st <= lfc_pkg::LFC_COVER_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign O_PRDATA                     = q.prdata;
  assign O_PREADY                     = q.pready;
  assign O_PSLVERR                    = q.pslverr;
  assign O_FULLSTEP_ENABLE_OUTPUT_PIN = q.en_pin;      // [RL7]
  assign O_FULLSTEP_ACTIVE            = q.fs_active;
  assign O_STEP_PAUSE                 = q.step_pause;
  assign O_FORCE_STEP                 = q.force_step;
  assign O_COVER_VALID                = q.cover_valid;
  assign O_COVER_DATA                 = q.cover_data;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);

  en_pin_follow_a: assert property ( // [RL10]
    (hs_variant && abs_vel >= fs_vel_ext) |=> O_FULLSTEP_ENABLE_OUTPUT_PIN)
    else $error("enable pin low although velocity at threshold");

  en_pin_variant_a: assert property ( // [RL9]
    !hs_variant |=> !O_FULLSTEP_ENABLE_OUTPUT_PIN)
    else $error("enable pin high outside handshake variant");

  fs_region_a: assert property ( // [RL18]
    1'b1 |=> O_FULLSTEP_ACTIVE ==
             $past(mode_on && (abs_vel > fs_vel_ext)))
    else $error("fullstep active flag wrong");

  force_step_a: assert property ( // [RL14]
    (mode_on && feedback && q.ls_tim != '0 &&
     q.ls_cnt == q.ls_tim - 32'h1) |=> O_FORCE_STEP ##1
      (!O_FORCE_STEP || q.ls_tim == 32'h1))
    else $error("step not forced at timer value");

  force_cause_a: assert property ( // [RL14]
    O_FORCE_STEP |-> $past(feedback) && $past(q.ls_tim) != '0)
    else $error("step forced without stalled feedback");

  cover_hold_a: assert property ( // [RL4]
    (O_COVER_VALID && !I_COVER_READY) |=>
      O_COVER_VALID && $stable(O_COVER_DATA))
    else $error("cover datagram dropped before taken");

  cover_high_a: assert property ( // [RL6]
    $rose(O_COVER_VALID) && q.side |-> O_COVER_DATA == $past(q.cov_hi))
    else $error("wrong datagram sent above switch velocity");

  cover_low_a: assert property ( // [RL5]
    $rose(O_COVER_VALID) && !q.side |-> O_COVER_DATA == $past(q.cov_lo))
    else $error("wrong datagram sent below switch velocity");

  cover_once_a: assert property ( // [RL19]
    (q.cov_st == lfc_pkg::LFC_COVER_IDLE && above_switch == q.side)
      |=> !$rose(O_COVER_VALID))
    else $error("cover datagram repeated without crossing");

  microstep_keep_a: assert property ( // [RL13]
    hs_variant |=> !O_STEP_PAUSE)
    else $error("steps paused in handshake variant");

  wo_read_zero_a: assert property ( // [RL16]
    (acc && !q.pready && !I_PWRITE && idx == lfc_pkg::IDX_FS_VEL)
      |=> O_PREADY && O_PRDATA == 32'h0)
    else $error("write-only register read not zero");

  pready_pulse_a: assert property (
    O_PREADY |=> !O_PREADY)
    else $error("ready held longer than one cycle");

  // a taken datagram must not be offered a second time
  cover_release_a: assert property ( // [RL4]
    (O_COVER_VALID && I_COVER_READY) |=> !O_COVER_VALID)
    else $error("cover datagram held after it was taken");

  ls_count_clear_a: assert property ( // [RL14]
    !feedback |=> q.ls_cnt == '0)
    else $error("low-speed count kept without feedback");

  step_pause_a: assert property ( // [RL13]
    (mode_on && !hs_variant && feedback) |=> O_STEP_PAUSE)
    else $error("steps not paused on feedback");

  wo_timer_zero_a: assert property ( // [RL17]
    (acc && !q.pready && !I_PWRITE && idx == lfc_pkg::IDX_LS_TIMER)
      |=> O_PREADY && O_PRDATA == 32'h0)
    else $error("write-only timer read not zero");

  cover_sent_c:   cover property ($rose(O_COVER_VALID) ##[1:20] I_COVER_READY);
  force_step_c:   cover property (O_FORCE_STEP);
  en_pin_rise_c:  cover property ($rose(O_FULLSTEP_ENABLE_OUTPUT_PIN));
  slverr_c:       cover property (O_PREADY && O_PSLVERR);

endmodule

// ==== src/lfc_pkg.sv ====
// constants and types shared by the fullstep control block
package lfc_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_GENERAL   = 10'h000;
  localparam logic [9:0] IDX_REFERENCE = 10'h001;
  localparam logic [9:0] IDX_DRV_OUT   = 10'h004;
  localparam logic [9:0] IDX_STATUS    = 10'h005;
  localparam logic [9:0] IDX_SW_VEL    = 10'h01d;
  localparam logic [9:0] IDX_FS_VEL    = 10'h060;
  localparam logic [9:0] IDX_LS_TIMER  = 10'h062;
  localparam logic [9:0] IDX_COVER_LO  = 10'h06c;
  localparam logic [9:0] IDX_COVER_HI  = 10'h06d;

  // apb address layout
  localparam int          ADDR_W      = 12;
  localparam int          IDX_LSB     = 2;
  localparam int          IDX_MSB     = 11;

  // fields
  localparam int          MODE_LSB    = 21;
  localparam int          MODE_MSB    = 22;
  localparam logic [1:0]  MODE_ON     = 2'h1;
  localparam int          AUTO_COVER  = 0;
  localparam int          FMT_LSB     = 0;
  localparam int          FMT_MSB     = 3;
  localparam logic [3:0]  FMT_HS_A    = 4'hd;
  localparam logic [3:0]  FMT_HS_B    = 4'hc;
  localparam int          FS_VEL_W    = 24;
  localparam int          LS_TIMER_W  = 32;

  // status bits
  localparam int          ST_FS_ACT   = 0;
  localparam int          ST_EN_PIN   = 1;
  localparam int          ST_FEEDBACK = 2;
  localparam int          ST_SIDE     = 3;
  localparam int          ST_BUSY     = 4;
  localparam int          ST_HS       = 5;

  localparam logic [31:0] REG_RESET   = 32'h0000_0000;

  typedef enum logic {
    LFC_COVER_IDLE,
    LFC_COVER_SEND
  } lfc_cover_state_t;

endpackage

// ==== src/lfc_sync3.sv ====
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module lfc_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_pin,
  output logic      o_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } lfc_sync_state_t;

  lfc_sync_state_t q;
  lfc_sync_state_t d;

  // first stage feeds only the second; level moves once stages 2 and 3 agree
  always_comb begin
    d    = q;
    d.s1 = i_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.level = q.s3;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.level;

endmodule

// ==== verif/lfc_drv_model.sv ====
// behavioural stepper driver at the far side of the fullstep handshake
`timescale 1ns/1ps
module lfc_drv_model (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_fs_en,
  input  wire logic        i_overload,
  input  wire logic        i_slow,
  input  wire logic        i_cover_valid,
  input  wire logic [31:0] i_cover_data,
  output logic             o_feedback,
  output logic             o_cover_ready,
  output logic [31:0]      o_last_cover,
  output logic [7:0]       o_cover_cnt
);
  logic [2:0] pos_q;
  logic       fs_q;
  logic [2:0] wait_q;

  // feedback only while fullstep engaged and load is too high
  assign o_feedback = fs_q & i_overload;

  // fullstep position counter, datagram port with slow option
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_q <= 3'h0;
      fs_q <= 1'b0;
      wait_q <= 3'h0;
      o_cover_ready <= 1'b0;
      o_last_cover <= 32'h0;
      o_cover_cnt <= 8'h0;
    end else begin
      pos_q <= pos_q + 3'h1;
      if (!i_fs_en) fs_q <= 1'b0;
      else if (pos_q == 3'h7) fs_q <= 1'b1;
      o_cover_ready <= 1'b0;
      if (i_cover_valid && o_cover_ready) begin
        o_last_cover <= i_cover_data;
        o_cover_cnt <= o_cover_cnt + 8'h1;
        wait_q <= 3'h0;
      end else if (i_cover_valid) begin
        wait_q <= wait_q + 3'h1;
        o_cover_ready <= !i_slow || wait_q == 3'h3;
      end
    end
  end
endmodule

// ==== verif/lfc_tb_top.sv ====
// self-checking bench for the fullstep control block
`timescale 1ns/1ps
module lfc_tb_top;
  logic        clk, rstn, psel, penable, pwrite, ready, slow, ovl;
  logic        fb, en, act, pause, frc, cval, err_v, cready, fb_tb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, vel, cdat, rd_v, lastc;
  logic [7:0]  ccnt;
  int          error_cnt, tests_run, cyc;

  lfc_top uut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(ready),
    .O_PSLVERR(err_v), .I_ACTUAL_VELOCITY(vel),
    .I_FEEDBACK_INPUT_PIN(fb | fb_tb),
    .O_FULLSTEP_ENABLE_OUTPUT_PIN(en), .O_FULLSTEP_ACTIVE(act),
    .O_STEP_PAUSE(pause), .O_FORCE_STEP(frc), .O_COVER_VALID(cval),
    .O_COVER_DATA(cdat), .I_COVER_READY(cready));
  lfc_drv_model drv (.i_clk(clk), .i_rstn(rstn), .i_fs_en(en),
    .i_overload(ovl), .i_slow(slow), .i_cover_valid(cval),
    .i_cover_data(cdat), .o_feedback(fb), .o_cover_ready(cready),
    .o_last_cover(lastc), .o_cover_cnt(ccnt));

  ////////////////////////////////////////////////////////////////////
  // clock and hang guard; the whole run needs far fewer cycles
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end

  task report_and_stop();
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  task t_regs();
    apb(1'b0, lfc_pkg::IDX_GENERAL, 32'h0);
    chk(rd_v, lfc_pkg::REG_RESET);
    apb(1'b1, lfc_pkg::IDX_COVER_LO, 32'h0a5a_0011);
    apb(1'b1, lfc_pkg::IDX_COVER_HI, 32'h0b6b_0022);
    apb(1'b0, lfc_pkg::IDX_COVER_LO, 32'h0);
    chk(rd_v, 32'h0a5a_0011);
    apb(1'b0, lfc_pkg::IDX_COVER_HI, 32'h0);
    chk(rd_v, 32'h0b6b_0022);
    apb(1'b1, lfc_pkg::IDX_FS_VEL, 32'hff00_0040);
    apb(1'b0, lfc_pkg::IDX_FS_VEL, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b1, lfc_pkg::IDX_LS_TIMER, 32'h5);
    apb(1'b0, lfc_pkg::IDX_LS_TIMER, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b0, 10'h3ff, 32'h0);
    chk({rd_v[30:0], err_v}, 32'h1);
  endtask

  task setv(input logic [31:0] v, input logic e, input logic a);
    vel <= v;
    tick(4);
    chk({31'h0, en}, {31'h0, e});
    chk({31'h0, act}, {31'h0, a});
  endtask

  // handshake selection by format and mode, threshold kept to 24 bits
  task t_hs();
    logic [3:0] f [4];
    logic [31:0] st;
    f = '{4'hd, 4'hc, 4'hb, 4'h0};
    apb(1'b1, lfc_pkg::IDX_GENERAL, 32'h0020_0000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, lfc_pkg::IDX_DRV_OUT, {28'h0, f[i]});
      setv(32'h40, i < 2, 1'b0);
    end
    apb(1'b1, lfc_pkg::IDX_DRV_OUT, 32'hd);
    setv(32'h3f, 1'b0, 1'b0);
    setv(32'hffff_ffbf, 1'b1, 1'b1);
    setv(32'h41, 1'b1, 1'b1);
    chk({31'h0, pause}, 32'h0);
    // status: fullstep active, enable pin high, handshake selected
    st = (32'h1 << lfc_pkg::ST_FS_ACT) | (32'h1 << lfc_pkg::ST_EN_PIN) |
         (32'h1 << lfc_pkg::ST_HS);
    apb(1'b0, lfc_pkg::IDX_STATUS, 32'h0);
    chk(rd_v, st);
    apb(1'b1, lfc_pkg::IDX_GENERAL, 32'h0040_0000);
    setv(32'h41, 1'b0, 1'b0);
  endtask

  // automatic cover datagrams, once per crossing, slow port stalls
  task t_cover();
    setv(32'h0, 1'b0, 1'b0);
    apb(1'b1, lfc_pkg::IDX_SW_VEL, 32'h3c);
    apb(1'b1, lfc_pkg::IDX_REFERENCE, 32'h1);
    tick(10);
    chk({24'h0, ccnt}, 32'h0);
    slow <= 1'b1;
    vel <= 32'h101;
    tick(20);
    chk({24'h0, ccnt}, 32'h1);
    chk(lastc, 32'h0b6b_0022);
    vel <= 32'hffff_fe00;
    tick(20);
    chk({24'h0, ccnt}, 32'h1);
    slow <= 1'b0;
    vel <= 32'h0;
    tick(10);
    chk({24'h0, ccnt}, 32'h2);
    chk(lastc, 32'h0a5a_0011);
  endtask

  // forced step period equals the timer value while feedback stays high
  task t_force();
    int n;
    apb(1'b1, lfc_pkg::IDX_GENERAL, 32'h0020_0000);
    vel <= 32'h40;
    ovl <= 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (frc !== 1'b1 && n < 60);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (frc !== 1'b1 && n < 20);
    chk(n, 32'h5);
    chk({31'h0, pause}, 32'h0);
    ovl <= 1'b0;
    tick(8);
    n = 0;
    repeat (20) begin
      tick(1);
      n += (frc === 1'b1);
    end
    chk(n, 32'h0);
    // outside the handshake the block itself pauses steps on feedback
    apb(1'b1, lfc_pkg::IDX_DRV_OUT, 32'hb);
    fb_tb <= 1'b1;
    tick(8);
    chk({31'h0, pause}, 32'h1);
    apb(1'b1, lfc_pkg::IDX_DRV_OUT, 32'hd);
    tick(2);
    chk({31'h0, pause}, 32'h0);
    fb_tb <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, slow, ovl, fb_tb} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    vel = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    tick(6);
    rstn <= 1'b1;
    t_regs();
    t_hs();
    t_cover();
    t_force();
    report_and_stop();
  end
endmodule
